// [sfp_defines.vh]
// sfp_defines.vh: offsets, fields, reset values and codes of the spi flash port
// assumes inclusion by bare name from the design file; definitions only
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH

// ----------------
// register offsets (sfr space below 0x100, io ram above)
// ----------------
`define SFP_OFS_IRQ_FLAG 16'h00F8
`define SFP_OFS_CMD 16'h00FD
`define SFP_OFS_MODE_SEL 16'h2080
`define SFP_OFS_MODE_STB 16'h2081
`define SFP_OFS_IRQ_EN 16'h2701
`define SFP_OFS_STAT 16'h2708
`define SFP_OFS_CTRL 16'h270C

// ----------------
// field positions
// ----------------
`define SFP_BIT_IRQ 7
`define SFP_BIT_PORT_EN 4
`define SFP_BIT_SAFE 3

// ----------------
// reset values
// ----------------
`define SFP_RST_PORT_EN 1'b1
`define SFP_RST_SAFE 1'b0
`define SFP_RST_IRQ 1'b0
`define SFP_RST_STAT 6'h00
`define SFP_RST_CMD 8'h00

// ----------------
// mode codes, write window, byte slots
// ----------------
`define SFP_SEL_ERASE 8'hD1
`define SFP_SEL_READBACK 8'h2E
`define SFP_STB_KEY 8'h96
`define SFP_UNLOCK 4'h2
`define SFP_SAFE_LO 16'h0400
`define SFP_SAFE_HI 16'h040F
`define SFP_IDX_LO 3'd1
`define SFP_IDX_CMD 3'd2
`define SFP_IDX_STAT 3'd3
`define SFP_IDX_DATA 3'd4
`define SFP_CNT_SHORT 3'b111

`endif

// [sfp_host_model.sv]
// sfp_host_model.sv: behavioural spi host, mode 0, msb first, 160 ns sck
// assumes the bench calls frame() and reads rx_buf afterwards
`timescale 1ns/1ps
module sfp_host_model (
    // pins toward the port
    output reg port_select_n,
    output reg spi_sck,
    output reg spi_mosi,
    // answer from the port
    input wire spi_miso_o,
    input wire spi_miso_oe
);
    reg [7:0] rx_buf [0:7];
    // idle: deselected, clock parked low
    initial begin
        port_select_n = 1'b1;
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
    end
    // one frame of n bytes, first byte in tx[47:40]; an undriven miso reads x
    task frame(input [3:0] n, input [47:0] tx);
        integer i;
        integer b;
        begin
            #37 port_select_n = 1'b0;
            for (i = 0; i < n; i = i + 1) begin
                for (b = 7; b >= 0; b = b - 1) begin
                    spi_mosi = tx[40 - 8 * i + b];
                    #80 spi_sck = 1'b1;
                    rx_buf[i][b] = spi_miso_oe ? spi_miso_o : 1'bx;
                    #80 spi_sck = 1'b0;
                end
            end
            #80 port_select_n = 1'b1;
            spi_mosi = ~spi_mosi; // released line must not look meaningful
        end
    endtask
endmodule

// [sfp_spi_slave.v]
// sfp_spi_slave.v: spi slave port with memory access and flash programming mode
// assumes spi mode 0 pins from outside (synchronised here), a memory bus
// with one-cycle ack, and mpu register accesses on the same clock
//
// Functional notes
// - a one-byte transaction always loads the command register, and interrupts outside flash mode
// - longer transactions: address word, command, status out, then data bytes
// - read command returns data from address, incrementing; cmd/irq unless 0x80
// - write command stores data from address, incrementing outside flash mode; cmd/irq unless 0x00
// - irq flag set by hardware, cleared by writing 0; enable resets to 0
// - port enable resets to 1; when 0 the port is off
// - outside flash mode, safe mode drops writes outside the 16 byte window
// - status bit 7 flags not-ready in the previous transaction
// - status bit 6 sent-data parity, bit 5 received-byte parity
// - status bits 4:2 low data count; short transactions give 111
// - bit 1 flash mode gated by test pin; bit 0 flash ready
// - in flash mode all accesses go to flash, not ram
// - flash writes hold the first data byte and commit it with each later byte as one word
// - large variant: one-byte transaction in flash mode sets bank select
// - flash mode halts the mpu, no interrupts, left only by reset
// - entry needs emulator on, flag_a clear, not secure, unlock key 0010
// - mode select and strobe are reachable only from spi
// - select 0xD1 erase entry, 0x2E readback when not secure, else none
// - strobe 0x96 enters if select valid; every strobe that safe mode lets through clears select
// - entry halts mpu, stops compute engine, resets flash logic; erases only after select 0xD1
// - chip select high holds the port in reset with output released
// - command msb selects read (1) or write (0)
`timescale 1ns/1ps
`include "sfp_defines.vh"

module sfp_spi_slave #(
    parameter LARGE_FLASH = 1
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // spi pins
    input wire port_select_n,
    input wire spi_sck,
    input wire spi_mosi,
    output wire spi_miso_o,
    output wire spi_miso_oe,
    output wire spi_pins_enabled,
    // mpu register port
    input wire reg_sfr,
    input wire [15:0] reg_addr,
    input wire reg_we,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output wire spi_irq_req,
    // memory and flash bus
    output reg mem_req,
    output reg mem_we,
    output reg mem_wide,
    output wire mem_flash,
    output reg [15:0] mem_addr,
    output reg [15:0] mem_wdata,
    input wire mem_ack,
    input wire [7:0] mem_rdata,
    // flash mode environment
    input wire emulator_enable,
    input wire flag_a,
    input wire secure_bit,
    input wire [3:0] flash_unlock_key,
    input wire test_pin,
    input wire flash_ready,
    input wire erase_done,
    output reg flash_programming_mode,
    output wire mpu_halt,
    output wire ce_disable,
    output reg flash_ctl_reset,
    output reg mass_erase_start,
    output reg secure_clear,
    output reg [1:0] flash_bank_select
);

// ----------------
// state
// ----------------
reg [2:0] sck_q;
reg [1:0] cs_q;
reg [1:0] mosi_q;
reg [1:0] tst_q;
reg active_q;
reg [2:0] bit_q;
reg [7:0] rx_q;
reg [7:0] tx_q;
reg load_q;
reg [2:0] idx_q;
reg many_q;
reg [15:0] addr_q;
reg [7:0] cmd_q;
reg [7:0] even_q;
reg pair_q;
reg err_q;
reg txp_q;
reg rxp_q;
reg [7:0] rd_buf_q;
reg rd_vld_q;
reg [5:0] stat_q;
reg [7:0] cmd_reg_q;
reg [7:0] sel_q;
reg irq_q;
reg ien_q;
reg port_en_q;
reg safe_q;

// ----------------
// pin sampling and edges
// ----------------
// two flops on every pin, a third on sck; edge detect looks only at the second and third
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        sck_q <= 3'b000;
        cs_q <= 2'b11;
        mosi_q <= 2'b00;
        tst_q <= 2'b00;
        active_q <= 1'b0;
    end else begin
        sck_q <= {sck_q[1:0], spi_sck};
        cs_q <= {cs_q[0], port_select_n};
        mosi_q <= {mosi_q[0], spi_mosi};
        tst_q <= {tst_q[0], test_pin};
        active_q <= ~cs_q[1] & port_en_q;
    end
end

wire active = ~cs_q[1] & port_en_q;
wire sck_rise = active & sck_q[1] & ~sck_q[2];
wire sck_fall = active & ~sck_q[1] & sck_q[2];
wire end_txn = active_q & ~active;
wire [7:0] rx_byte = {rx_q[6:0], mosi_q[1]};
wire byte_done = sck_rise & (bit_q == 3'd7);

// byte slot decode of the byte just completed
wire is_cmd = ~many_q & (idx_q == `SFP_IDX_CMD);
wire is_lo = ~many_q & (idx_q == `SFP_IDX_LO);
wire is_hi = ~many_q & (idx_q == 3'd0);
wire is_data = many_q;
wire rd_cmd = cmd_q[7];

// ----------------
// flash mode gating
// ----------------
wire entry_ok = emulator_enable & ~flag_a & ~secure_bit & (flash_unlock_key == `SFP_UNLOCK);
wire sel_erase = (sel_q == `SFP_SEL_ERASE);
wire sel_ok = entry_ok & (sel_erase | ((sel_q == `SFP_SEL_READBACK) & ~secure_bit));

// ----------------
// status byte: stored part plus live flash bits
// ----------------
wire [7:0] stat_rd = {stat_q, flash_programming_mode & tst_q[1], flash_programming_mode & flash_ready};

// ----------------
// transaction end: command register and interrupt events
// ----------------
wire single = ~many_q & (idx_q == 3'd1);
wire multi = many_q | (idx_q == `SFP_IDX_STAT);
wire cmd_upd = end_txn & (single | (multi & (|cmd_q[6:0])));
wire irq_set = cmd_upd & ~flash_programming_mode;
wire [7:0] cmd_new = single ? addr_q[15:8] : cmd_q;

// write target checks
wire in_window = (addr_q >= `SFP_SAFE_LO) & (addr_q <= `SFP_SAFE_HI);
wire wr_allowed = ~safe_q | in_window;

// memory request issue, shared by reads and writes
wire busy = mem_req & ~mem_ack;

// ----------------
// serial engine and memory sequencing
// ----------------
// the frame counters and flags clear while the port is deselected, so a new frame
// always starts from byte slot zero whatever the last one left behind
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        bit_q <= 3'd0;
        rx_q <= 8'h00;
        tx_q <= 8'h00;
        load_q <= 1'b0;
        idx_q <= 3'd0;
        many_q <= 1'b0;
        addr_q <= 16'h0000;
        cmd_q <= 8'h00;
        even_q <= 8'h00;
        pair_q <= 1'b0;
        err_q <= 1'b0;
        txp_q <= 1'b0;
        rxp_q <= 1'b0;
        rd_buf_q <= 8'h00;
        rd_vld_q <= 1'b0;
        stat_q <= `SFP_RST_STAT;
        sel_q <= 8'h00;
        mem_req <= 1'b0;
        mem_we <= 1'b0;
        mem_wide <= 1'b0;
        mem_addr <= 16'h0000;
        mem_wdata <= 16'h0000;
        flash_programming_mode <= 1'b0;
        flash_ctl_reset <= 1'b0;
        mass_erase_start <= 1'b0;
    end else begin
        flash_ctl_reset <= 1'b0;
        mass_erase_start <= 1'b0;
        if (mem_ack) begin
            mem_req <= 1'b0;
            if (!mem_we) begin
                rd_buf_q <= mem_rdata;
                rd_vld_q <= 1'b1;
            end
        end
        if (end_txn && (many_q || idx_q != 3'd0)) begin
            // error, parities and data count of the finished frame
            stat_q[5] <= err_q | (bit_q != 3'd0);
            stat_q[4] <= txp_q;
            stat_q[3] <= rxp_q;
            stat_q[2:0] <= many_q ? idx_q + `SFP_IDX_DATA : `SFP_CNT_SHORT;
        end
        if (!active) begin
            bit_q <= 3'd0;
            tx_q <= 8'h00;
            load_q <= 1'b0;
            idx_q <= 3'd0;
            many_q <= 1'b0;
            pair_q <= 1'b0;
            err_q <= 1'b0;
            txp_q <= 1'b0;
            rxp_q <= 1'b0;
            rd_vld_q <= 1'b0;
        end else begin
            if (sck_rise) begin
                bit_q <= bit_q + 3'd1;
                rx_q <= rx_byte;
            end
            if (byte_done) begin
                load_q <= 1'b1;
                idx_q <= idx_q + 3'd1;
                rxp_q <= rxp_q ^ (^rx_byte);
                if (idx_q == `SFP_IDX_STAT)
                    many_q <= 1'b1;
                if (is_hi)
                    addr_q[15:8] <= rx_byte;
                if (is_lo)
                    addr_q[7:0] <= rx_byte;
                if (is_cmd) begin
                    cmd_q <= rx_byte;
                    // prefetch the first byte so it is ready after status
                    if (rx_byte[7]) begin
                        if (busy) begin
                            err_q <= 1'b1;
                        end else begin
                            mem_req <= 1'b1;
                            mem_we <= 1'b0;
                            mem_wide <= 1'b0;
                            mem_addr <= addr_q;
                        end
                    end
                end
                if (is_data && !rd_cmd) begin
                    if (flash_programming_mode) begin
                        // first data byte is held, every later byte commits a word with it
                        if (!pair_q) begin
                            even_q <= rx_byte;
                            pair_q <= 1'b1;
                        end else if (busy) begin
                            err_q <= 1'b1;
                        end else begin
                            mem_req <= 1'b1;
                            mem_we <= 1'b1;
                            mem_wide <= 1'b1;
                            mem_addr <= addr_q;
                            mem_wdata <= {rx_byte, even_q};
                        end
                    end else begin
                        addr_q <= addr_q + 16'h0001;
                        if (addr_q == `SFP_OFS_MODE_SEL) begin
                            if (wr_allowed)
                                sel_q <= rx_byte;
                        end else if (addr_q == `SFP_OFS_MODE_STB) begin
                            if (wr_allowed) begin
                                sel_q <= 8'h00;
                                if (rx_byte == `SFP_STB_KEY && sel_ok) begin
                                    flash_programming_mode <= 1'b1;
                                    flash_ctl_reset <= 1'b1;
                                    mass_erase_start <= sel_erase;
                                end
                            end
                        end else if (wr_allowed) begin
                            if (busy) begin
                                err_q <= 1'b1;
                            end else begin
                                mem_req <= 1'b1;
                                mem_we <= 1'b1;
                                mem_wide <= 1'b0;
                                mem_addr <= addr_q;
                                mem_wdata <= {8'h00, rx_byte};
                            end
                        end
                    end
                end
            end
            // the falling edge after a full byte loads the next outgoing byte
            if (sck_fall) begin
                if (load_q) begin
                    load_q <= 1'b0;
                    if (~many_q && idx_q == `SFP_IDX_STAT) begin
                        tx_q <= stat_rd;
                    end else if (many_q && rd_cmd) begin
                        tx_q <= rd_buf_q;
                        txp_q <= txp_q ^ (^rd_buf_q);
                        rd_vld_q <= 1'b0;
                        if (!rd_vld_q)
                            err_q <= 1'b1;
                        // fetch the following address while this byte shifts
                        if (busy) begin
                            err_q <= 1'b1;
                        end else begin
                            mem_req <= 1'b1;
                            mem_we <= 1'b0;
                            mem_wide <= 1'b0;
                            mem_addr <= addr_q + 16'h0001;
                        end
                        addr_q <= addr_q + 16'h0001;
                    end else begin
                        tx_q <= 8'h00;
                    end
                end else begin
                    tx_q <= {tx_q[6:0], 1'b0};
                end
            end
        end
    end
end

// ----------------
// mpu registers
// ----------------
// mode select and strobe have no decode here: the mpu cannot reach them
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        irq_q <= `SFP_RST_IRQ;
        ien_q <= `SFP_RST_IRQ;
        port_en_q <= `SFP_RST_PORT_EN;
        safe_q <= `SFP_RST_SAFE;
        cmd_reg_q <= `SFP_RST_CMD;
        reg_rdata <= 8'h00;
        flash_bank_select <= 2'b00;
        secure_clear <= 1'b0;
    end else begin
        // a hardware set in the same cycle as a software clear wins
        if (reg_we && reg_sfr && reg_addr == `SFP_OFS_IRQ_FLAG)
            irq_q <= irq_set | (irq_q & reg_wdata[`SFP_BIT_IRQ]);
        else if (irq_set)
            irq_q <= 1'b1;
        if (reg_we && !reg_sfr && reg_addr == `SFP_OFS_IRQ_EN)
            ien_q <= reg_wdata[`SFP_BIT_IRQ];
        if (reg_we && !reg_sfr && reg_addr == `SFP_OFS_CTRL) begin
            port_en_q <= reg_wdata[`SFP_BIT_PORT_EN];
            safe_q <= reg_wdata[`SFP_BIT_SAFE];
        end
        if (cmd_upd)
            cmd_reg_q <= cmd_new;
        if (end_txn && single && flash_programming_mode && LARGE_FLASH != 0)
            flash_bank_select <= addr_q[9:8];
        secure_clear <= erase_done;
        reg_rdata <= 8'h00;
        if (reg_sfr) begin
            if (reg_addr == `SFP_OFS_IRQ_FLAG)
                reg_rdata[`SFP_BIT_IRQ] <= irq_q;
            if (reg_addr == `SFP_OFS_CMD)
                reg_rdata <= cmd_reg_q;
        end else begin
            if (reg_addr == `SFP_OFS_IRQ_EN)
                reg_rdata[`SFP_BIT_IRQ] <= ien_q;
            if (reg_addr == `SFP_OFS_STAT)
                reg_rdata <= stat_rd;
            if (reg_addr == `SFP_OFS_CTRL) begin
                reg_rdata[`SFP_BIT_PORT_EN] <= port_en_q;
                reg_rdata[`SFP_BIT_SAFE] <= safe_q;
            end
        end
    end
end

// ----------------
// outputs
// ----------------
assign spi_miso_o = tx_q[7];
assign spi_miso_oe = active;
assign spi_pins_enabled = port_en_q;
assign spi_irq_req = irq_q & ien_q;
assign mem_flash = flash_programming_mode;
// mode sticks until reset; halting the mpu also keeps it from clearing
assign mpu_halt = flash_programming_mode;
assign ce_disable = flash_programming_mode;

endmodule

// [sfp_spi_slave_sva.sv]
// sfp_spi_slave_sva.sv: concurrent checks on the pins of the spi flash port
// assumes a bind onto sfp_spi_slave, one clock domain, async reset_n
`timescale 1ns/1ps
module sfp_spi_slave_sva #(
    parameter LARGE_FLASH = 1
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // spi side
    input wire port_select_n,
    input wire spi_miso_oe,
    input wire spi_pins_enabled,
    input wire spi_irq_req,
    // memory bus
    input wire mem_req,
    input wire mem_we,
    input wire mem_wide,
    input wire mem_flash,
    input wire [15:0] mem_addr,
    input wire mem_ack,
    // flash mode
    input wire emulator_enable,
    input wire flag_a,
    input wire secure_bit,
    input wire [3:0] flash_unlock_key,
    input wire erase_done,
    input wire flash_programming_mode,
    input wire mpu_halt,
    input wire ce_disable,
    input wire flash_ctl_reset,
    input wire secure_clear
);
    // ----------------
    // clocking
    // ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ----------------
    // checks
    // ----------------
    // four samples cover the two-flop select pipeline
    a_cs_release: assert property (port_select_n [*4] |-> !spi_miso_oe)
        else $error("miso driven while deselected");
    a_port_off: assert property (!spi_pins_enabled |-> !spi_miso_oe)
        else $error("miso driven while port disabled");
    a_mode_sticky: assert property (flash_programming_mode |=> flash_programming_mode)
        else $error("flash mode left without reset");
    a_halt_mode: assert property (mpu_halt == flash_programming_mode && ce_disable == mpu_halt)
        else $error("halt or engine stop differs from flash mode");
    a_entry_gate: assert property ($rose(flash_programming_mode) |-> $past(emulator_enable) && !$past(flag_a)
        && !$past(secure_bit) && $past(flash_unlock_key) == 4'h2)
        else $error("flash mode entered without its conditions");
    a_entry_reset: assert property ($rose(flash_programming_mode) |-> flash_ctl_reset)
        else $error("no flash control reset on entry");
    a_no_irq_sfm: assert property (flash_programming_mode |-> !$rose(spi_irq_req))
        else $error("interrupt raised in flash mode");
    a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before ack");
    a_bus_space: assert property (mem_flash == flash_programming_mode)
        else $error("memory space differs from mode");
    a_word_sfm: assert property (mem_req && mem_wide |-> flash_programming_mode && mem_we)
        else $error("word write outside flash mode");
    a_secure_clr: assert property (erase_done |=> secure_clear)
        else $error("security not cleared after erase");
    // main scenarios
    c_entry: cover property ($rose(flash_programming_mode));
    c_write: cover property (mem_req && mem_ack && mem_we);
    c_word: cover property (mem_req && mem_ack && mem_wide);
    c_irq: cover property ($rose(spi_irq_req));
endmodule

// [sfp_spi_slave_tb.sv]
// sfp_spi_slave_tb.sv: self-checking bench of the spi flash port
// assumes sfp_spi_slave, the host model and the checker are compiled before it
`timescale 1ns/1ps
module sfp_spi_slave_tb;
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg reg_sfr = 1'b0;
    reg [15:0] reg_addr = 16'h0000;
    reg reg_we = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    reg mem_ack = 1'b0;
    reg test_pin = 1'b0;
    reg erase_done = 1'b0;
    reg secure_bit = 1'b0;
    reg erase_seen = 1'b0;
    reg w_wide = 1'b0;
    reg [15:0] w_addr = 16'h0000;
    reg [15:0] w_data = 16'h0000;
    integer n_wr = 0;
    integer nw;
    integer k;
    integer n_mismatch = 0;
    integer samples_checked = 0;
    wire port_select_n, spi_sck, spi_mosi, spi_miso_o, spi_miso_oe, spi_pins_enabled;
    wire [7:0] reg_rdata;
    wire spi_irq_req, mem_req, mem_we, mem_wide, mem_flash;
    wire [15:0] mem_addr, mem_wdata;
    wire flash_programming_mode, mpu_halt, ce_disable, flash_ctl_reset, mass_erase_start, secure_clear;
    wire [1:0] flash_bank_select;
    wire [7:0] mem_rdata = mem_addr[7:0] ^ 8'hA5;
    // ----------------
    // clock, design, partner
    // ----------------
    always #5 clk = ~clk;
    sfp_spi_slave i_dut (.clk(clk), .reset_n(reset_n), .port_select_n(port_select_n),
        .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
        .spi_pins_enabled(spi_pins_enabled), .reg_sfr(reg_sfr), .reg_addr(reg_addr), .reg_we(reg_we),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .spi_irq_req(spi_irq_req), .mem_req(mem_req),
        .mem_we(mem_we), .mem_wide(mem_wide), .mem_flash(mem_flash), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .emulator_enable(1'b1),
        .flag_a(1'b0), .secure_bit(secure_bit), .flash_unlock_key(4'h2), .test_pin(test_pin),
        .flash_ready(1'b1), .erase_done(erase_done), .flash_programming_mode(flash_programming_mode),
        .mpu_halt(mpu_halt), .ce_disable(ce_disable), .flash_ctl_reset(flash_ctl_reset),
        .mass_erase_start(mass_erase_start), .secure_clear(secure_clear),
        .flash_bank_select(flash_bank_select));
    sfp_host_model i_host (.port_select_n(port_select_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
        .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe));
    // memory and flash answer every request one cycle later; writes are logged
    always @(posedge clk) begin
        #1;
        mem_ack = mem_req & ~mem_ack;
        erase_done = mass_erase_start;
        if (mass_erase_start) erase_seen = 1'b1;
        if (mem_ack & mem_we) begin
            w_addr = mem_addr;
            w_data = mem_wdata;
            w_wide = mem_wide;
            n_wr = n_wr + 1;
        end
    end
    // ----------------
    // tasks
    // ----------------
    task chk(input [8*8:1] nm, input [15:0] seen, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("Error %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // register read: data is registered, so it is taken one edge later
    task rc(input [15:0] a, input s, input [7:0] m, input [7:0] e);
        begin
            @(posedge clk) #1 reg_addr = a;
            reg_sfr = s;
            @(posedge clk) #1 chk("register", reg_rdata & m, e);
        end
    endtask
    task wr(input [15:0] a, input s, input [7:0] d);
        begin
            @(posedge clk) #1 reg_addr = a;
            reg_sfr = s;
            reg_wdata = d;
            reg_we = 1'b1;
            @(posedge clk) #1 reg_we = 1'b0;
        end
    endtask
    // the gap lets the select-rise processing finish before the next access
    task spi(input [3:0] n, input [47:0] b);
        begin
            i_host.frame(n, b);
            repeat (12) @(posedge clk);
            #1;
        end
    endtask
    task wrsp(input [15:0] a, input [7:0] d);
        spi(5, {a, 16'h0000, d, 8'h00});
    endtask
    task do_reset;
        begin
            reset_n = 1'b0;
            repeat (5) @(posedge clk);
            #1 reset_n = 1'b1;
            repeat (3) @(posedge clk);
            #1;
        end
    endtask
    // ----------------
    // watchdog and tests
    // ----------------
    initial begin
        #400_000;
        n_mismatch = n_mismatch + 1;
        print_verdict;
    end
    initial begin
        do_reset;
        rc(16'h2708, 1'b0, 8'hFF, 8'h00);
        rc(16'h270C, 1'b0, 8'h18, 8'h10);
        rc(16'h2701, 1'b0, 8'h80, 8'h00);
        rc(16'h00F8, 1'b1, 8'h80, 8'h00);
        rc(16'h3000, 1'b0, 8'hFF, 8'h00);
        wr(16'h2701, 1'b0, 8'h80);
        spi(1, {8'h5A, 40'h0});
        rc(16'h00FD, 1'b1, 8'hFF, 8'h5A);
        chk("irq_req", spi_irq_req, 1);
        wr(16'h00F8, 1'b1, 8'h00);
        chk("irq_req", spi_irq_req, 0);
        spi(6, {16'h1234, 8'h81, 24'h0});
        chk("rd0", i_host.rx_buf[4], 8'h91);
        chk("rd1", i_host.rx_buf[5], 8'h90);
        rc(16'h00FD, 1'b1, 8'hFF, 8'h81);
        rc(16'h00F8, 1'b1, 8'h80, 8'h80);
        rc(16'h2708, 1'b0, 8'hFC, {1'h0, ^(8'h91 ^ 8'h90), ^(8'h12 ^ 8'h34 ^ 8'h81), 3'h2, 2'h0});
        wr(16'h00F8, 1'b1, 8'h00);
        spi(5, {16'h1234, 8'h80, 24'h0});
        rc(16'h00F8, 1'b1, 8'h80, 8'h00);
        rc(16'h00FD, 1'b1, 8'hFF, 8'h81);
        spi(5, {16'h0400, 8'h01, 8'h00, 8'h3C, 8'h00});
        chk("waddr", w_addr, 16'h0400);
        chk("wdata", w_data[7:0], 8'h3C);
        rc(16'h00FD, 1'b1, 8'hFF, 8'h01);
        wr(16'h00F8, 1'b1, 8'h00);
        wrsp(16'h0401, 8'h77);
        chk("wdata", w_data[7:0], 8'h77);
        rc(16'h00F8, 1'b1, 8'h80, 8'h00);
        spi(3, {16'h0000, 8'h80, 24'h0});
        rc(16'h2708, 1'b0, 8'h1C, 8'h1C);
        wr(16'h00F8, 1'b1, 8'h00);
        wr(16'h270C, 1'b0, 8'h00);
        chk("pins_en", spi_pins_enabled, 0);
        spi(1, {8'h77, 40'h0});
        rc(16'h00FD, 1'b1, 8'hFF, 8'h01);
        wr(16'h270C, 1'b0, 8'h18);
        nw = n_wr;
        wrsp(16'h0500, 8'h44);
        chk("n_wr", n_wr, nw);
        wrsp(16'h040F, 8'h55);
        chk("n_wr", n_wr, nw + 1);
        wr(16'h270C, 1'b0, 8'h10);
        wr(16'h2080, 1'b0, 8'hD1);
        wr(16'h2081, 1'b0, 8'h96);
        chk("mode", flash_programming_mode, 0);
        wrsp(16'h2080, 8'h55);
        wrsp(16'h2081, 8'h96);
        chk("mode", flash_programming_mode, 0);
        wrsp(16'h2080, 8'hD1);
        wrsp(16'h2081, 8'h12);
        wrsp(16'h2081, 8'h96);
        chk("mode", flash_programming_mode, 0);
        secure_bit = 1'b1;
        wrsp(16'h2080, 8'hD1);
        wrsp(16'h2081, 8'h96);
        chk("mode", flash_programming_mode, 0);
        secure_bit = 1'b0;
        // read-back entry first, then a mid-run reset and mass-erase entry
        for (k = 0; k < 2; k = k + 1) begin
            do_reset;
            erase_seen = 1'b0;
            wrsp(16'h2080, k ? 8'hD1 : 8'h2E);
            wrsp(16'h2081, 8'h96);
            chk("mode", flash_programming_mode, 1);
            chk("erase", erase_seen, k);
            chk("halt", mpu_halt, 1);
        end
        wr(16'h2701, 1'b0, 8'h80);
        rc(16'h2708, 1'b0, 8'h03, 8'h01);
        test_pin = 1'b1;
        repeat (4) @(posedge clk);
        rc(16'h2708, 1'b0, 8'h03, 8'h03);
        spi(6, {16'h0010, 8'h00, 8'h00, 8'h11, 8'h22});
        chk("waddr", w_addr, 16'h0010);
        chk("wword", w_data, 16'h2211);
        chk("wide", w_wide, 1);
        spi(5, {16'h0011, 8'h80, 24'h0});
        chk("frd", i_host.rx_buf[4], 8'hB4);
        spi(1, {8'h03, 40'h0});
        chk("bank", flash_bank_select, 2'h3);
        chk("irq_req", spi_irq_req, 0);
        print_verdict;
    end
endmodule
bind sfp_spi_slave sfp_spi_slave_sva #(.LARGE_FLASH(LARGE_FLASH)) i_sva (.clk(clk), .reset_n(reset_n),
    .port_select_n(port_select_n), .spi_miso_oe(spi_miso_oe), .spi_pins_enabled(spi_pins_enabled),
    .spi_irq_req(spi_irq_req), .mem_req(mem_req), .mem_we(mem_we), .mem_wide(mem_wide),
    .mem_flash(mem_flash), .mem_addr(mem_addr), .mem_ack(mem_ack), .emulator_enable(emulator_enable),
    .flag_a(flag_a), .secure_bit(secure_bit), .flash_unlock_key(flash_unlock_key), .erase_done(erase_done),
    .flash_programming_mode(flash_programming_mode), .mpu_halt(mpu_halt), .ce_disable(ce_disable),
    .flash_ctl_reset(flash_ctl_reset), .secure_clear(secure_clear));
